// ### rtl/mcpt_params.svh
// Constants of the multi-channel pulse width timer: widths, counts, reset values.
// Assumes inclusion by bare name from the match channel and timer files of the block.
`ifndef MCPT_PARAMS_SVH
`define MCPT_PARAMS_SVH

`define MCPT_CNT_W     32
`define MCPT_NUM_MATCH 7
`define MCPT_SEL_W     3
`define MCPT_TC_RST    32'h0000_0000
`define MCPT_PC_RST    32'h0000_0000
`define MCPT_MR_RST    32'h0000_0000

`endif

// ### rtl/mcpt_pkg.sv
// Types of the multi-channel pulse width timer.
// Assumes nothing of its surroundings.
package mcpt_pkg;

    // Count source selection, one-hot
    typedef enum logic [3:0] {
        MCPT_MODE_TIMER = 4'b0001,
        MCPT_MODE_RISE  = 4'b0010,
        MCPT_MODE_FALL  = 4'b0100,
        MCPT_MODE_BOTH  = 4'b1000
    } mcpt_mode_e;

endpackage

// ### rtl/mcpt_match_chan.sv
// One match channel: shadow value, release latch, active value, compare, flag.
// Assumes count and tick come from the timer on the same clock.
`timescale 1ns/1ps
`include "mcpt_params.svh"

module mcpt_match_chan
    import mcpt_pkg::*;
#(
    parameter int W = `MCPT_CNT_W
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         rel,
    input  wire logic         xfer_ok,
    input  wire logic [W-1:0] count,
    input  wire logic         tick,
    input  wire logic         irq_en,
    input  wire logic         flag_clr,
    output logic      [W-1:0] active_q,
    output logic              pending_q,
    output wire logic         hit,
    output logic              flag_q
);

    logic [W-1:0] shadow_q;
    wire          xfer   = pending_q & xfer_ok;
    // A release arriving during a transfer stays pending
    wire          pend_d = rel | (pending_q & ~xfer);
    wire          flag_d = (hit & irq_en) | (flag_q & ~flag_clr);

    assign hit = tick & (count == active_q);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shadow_q  <= W'(`MCPT_MR_RST);
            active_q  <= W'(`MCPT_MR_RST);
            pending_q <= 1'b0;
            flag_q    <= 1'b0;
        end else begin
            if (wr_en) begin
                shadow_q <= wr_data;
            end
            if (xfer) begin
                active_q <= shadow_q;
            end
            pending_q <= pend_d;
            flag_q    <= flag_d;
        end
    end

endmodule

// ### rtl/mcpt_timer.sv
// Multi-channel pulse width timer: prescaler, counter, seven match channels,
// six pulse outputs with single or double edge control.
// Assumes software drives the control ports from clk_sys logic; cap_in are pins.
`timescale 1ns/1ps
`include "mcpt_params.svh"

module mcpt_timer
    import mcpt_pkg::*;
#(
    parameter int CNT_W = `MCPT_CNT_W,
    parameter int NM    = `MCPT_NUM_MATCH
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  count_en,
    input  wire logic                  count_clear,
    input  wire logic                  pwm_mode_en,
    input  wire mcpt_mode_e            cnt_mode,
    input  wire logic                  cap_sel,
    input  wire logic [1:0]            cap_in,
    input  wire logic [CNT_W-1:0]      prescale_limit,
    input  wire logic                  mr_wr_en,
    input  wire logic [`MCPT_SEL_W-1:0] mr_wr_sel,
    input  wire logic [CNT_W-1:0]      mr_wr_data,
    input  wire logic [NM-1:0]         mr_release,
    input  wire logic [NM-1:0]         irq_en,
    input  wire logic [NM-1:0]         stop_en,
    input  wire logic [NM-1:0]         reset_en,
    input  wire logic [NM-1:0]         flag_clr,
    input  wire logic [NM-1:1]         out_en,
    input  wire logic [NM-1:2]         dbl_edge,
    output logic      [CNT_W-1:0]      timer_count,
    output logic      [CNT_W-1:0]      prescale_count,
    output wire logic [NM-1:0]         match_flag,
    output wire logic [NM-1:0]         release_pending,
    output wire logic                  running,
    output logic      [NM-1:1]         pwm_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Capture pin synchronisers
    // Stage two is the first that logic reads; stage three is edge history only

    logic [1:0] cap_s1_q;
    logic [1:0] cap_s2_q;
    logic [1:0] cap_s3_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cap_s1_q <= 2'h0;
            cap_s2_q <= 2'h0;
            cap_s3_q <= 2'h0;
        end else begin
            cap_s1_q <= cap_in;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
        end
    end

    wire cap_now  = cap_sel ? cap_s2_q[1] : cap_s2_q[0];
    wire cap_prev = cap_sel ? cap_s3_q[1] : cap_s3_q[0];
    wire cap_rise = cap_now & ~cap_prev;
    wire cap_fall = ~cap_now & cap_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Count source

    logic src;

    always_comb begin
        src = 1'b0;
        unique case (cnt_mode)
            MCPT_MODE_TIMER: src = 1'b1;
            MCPT_MODE_RISE:  src = cap_rise;
            MCPT_MODE_FALL:  src = cap_fall;
            MCPT_MODE_BOTH:  src = cap_rise | cap_fall;
            default:         src = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and counter

    logic [CNT_W-1:0] pc_q;
    logic [CNT_W-1:0] pc_d;
    logic [CNT_W-1:0] tc_q;
    logic [CNT_W-1:0] tc_d;
    logic             stopped_q;
    wire  [NM-1:0]    hit_w;
    wire  [NM-1:0]    reset_eff;
    wire              pc_hit;
    wire              tick;
    wire              clear_ev;
    wire              stop_ev;
    wire              stopped_d;
    wire              xfer_ok;

    // Halt survives count_clear; only count_en low releases it
    assign running = count_en & ~stopped_q & ~count_clear;

    assign pc_hit = src & (pc_q == prescale_limit);
    assign tick   = running & pc_hit;

    // Cycle match always clears in pulse mode
    assign reset_eff = reset_en | {{(NM-1){1'b0}}, pwm_mode_en};

    assign clear_ev = |(hit_w & reset_eff);

    assign stop_ev   = |(hit_w & stop_en);
    assign stopped_d = count_en & (stop_ev | stopped_q);

    // Limit lowered under the running count is met only after a full wrap,
    // so pulse count_clear whenever the limit changes
    // Prescaler count and wrap
    assign pc_d = count_clear       ? CNT_W'(`MCPT_PC_RST) :
                  !(running && src) ? pc_q :
                  pc_hit            ? CNT_W'(`MCPT_PC_RST) :
                  pc_q + CNT_W'(1);

    assign tc_d = count_clear ? CNT_W'(`MCPT_TC_RST) :
                  clear_ev    ? CNT_W'(`MCPT_TC_RST) :
                  stop_ev     ? tc_q :
                  tick        ? tc_q + CNT_W'(1) :
                  tc_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_q      <= CNT_W'(`MCPT_PC_RST);
            tc_q      <= CNT_W'(`MCPT_TC_RST);
            stopped_q <= 1'b0;
        end else begin
            pc_q      <= pc_d;
            tc_q      <= tc_d;
            stopped_q <= stopped_d;
        end
    end

    assign timer_count    = tc_q;
    assign prescale_count = pc_q;

    ////////////////////////////////////////////////////////////////////////////
    // Match channels

    // Transfer only at cycle start or on count_clear in pulse mode
    assign xfer_ok = hit_w[0] | ~pwm_mode_en | count_clear;

    logic [CNT_W-1:0] active_w [NM];

    // Write strobe decoded per channel; index 7 selects nothing

    for (genvar i = 0; i < NM; i++) begin : g_mch
        mcpt_match_chan #(
            .W (CNT_W)
        ) u_mch (
            .clk_sys   (clk_sys),
            .rst       (rst),
            .wr_en     (mr_wr_en && (mr_wr_sel == `MCPT_SEL_W'(i))),
            .wr_data   (mr_wr_data),
            .rel       (mr_release[i]),
            .xfer_ok   (xfer_ok),
            .count     (tc_q),
            .tick      (tick),
            .irq_en    (irq_en[i]),
            .flag_clr  (flag_clr[i]),
            .active_q  (active_w[i]),
            .pending_q (release_pending[i]),
            .hit       (hit_w[i]),
            .flag_q    (match_flag[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pulse outputs

    wire [NM-1:1] set_ev;
    wire [NM-1:1] clr_ev;
    wire [NM-1:1] out_d;

    // Output 1 is always single edge
    assign set_ev[1] = hit_w[0];
    assign clr_ev[1] = hit_w[1];

    // Rise from previous match with dbl_edge, else from cycle match; fall from own
    for (genvar n = 2; n < NM; n++) begin : g_sel
        assign set_ev[n] = dbl_edge[n] ? hit_w[n-1] : hit_w[0];
        assign clr_ev[n] = hit_w[n];
    end

    // Falling match wins a tie, so equal counts stay low
    // Outputs held low outside pulse mode
    assign out_d = {(NM-1){pwm_mode_en}} & out_en &
                   (~clr_ev & (set_ev | pwm_out));

    // Common rate from the cycle match
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwm_out <= '0;
        end else begin
            pwm_out <= out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    wire [NM-1:0] flag_set_w  = hit_w & irq_en;
    wire [NM-1:0] flag_keep_w = match_flag & ~flag_clr;

    prescale_wrap_a: assert property (
        (running && pc_hit && !count_clear) |=> (pc_q == '0)
    ) else $error("prescaler did not wrap at limit");

    count_tick_a: assert property (
        (tick && !clear_ev && !stop_ev && !count_clear) |=> (tc_q == $past(tc_q) + CNT_W'(1))
    ) else $error("counter did not advance on prescale wrap");

    counter_clear_a: assert property (
        (clear_ev && !count_clear) |=> (tc_q == '0)
    ) else $error("counter not cleared on match");

    cycle_clear_a: assert property (
        (pwm_mode_en && hit_w[0]) |=> (tc_q == '0)
    ) else $error("cycle match did not clear the counter");

    counter_halt_a: assert property (
        (stop_ev && !clear_ev && count_en && !count_clear)
            |=> (!running && tc_q == $past(tc_q)) ##1 (!count_en || $stable(tc_q))
    ) else $error("counter kept running after stop match");

    flag_set_a: assert property (
        (|flag_set_w) |=> ((match_flag & $past(flag_set_w)) == $past(flag_set_w))
    ) else $error("match flag not set on enabled match");

    flag_hold_a: assert property (
        (|flag_keep_w) |=> ((match_flag & $past(flag_keep_w)) == $past(flag_keep_w))
    ) else $error("match flag lost without a clear");

    release_gate_a: assert property (
        $changed(active_w[1]) |-> $past(release_pending[1] && xfer_ok)
    ) else $error("match value took effect without release at cycle start");

    single_rise_a: assert property (
        (pwm_mode_en && out_en[1] && hit_w[0] && !hit_w[1]) |=> pwm_out[1]
    ) else $error("single edge output did not rise at cycle start");

    double_edge_a: assert property (
        (pwm_mode_en && out_en[2] && dbl_edge[2] && hit_w[1] && !hit_w[2])
            |=> pwm_out[2] and (hit_w[2] |=> !pwm_out[2])
    ) else $error("double edge output missed its edges");

    timer_quiet_a: assert property (
        !pwm_mode_en |=> (pwm_out == '0)
    ) else $error("pulse output driven outside pulse mode");

    single_fall_a: assert property (
        (pwm_mode_en && hit_w[1]) |=> !pwm_out[1]
    ) else $error("single edge output did not fall on its match");

    cycle_hold_a: assert property (
        (pwm_mode_en && !count_clear && !hit_w[0]) |=> $stable(active_w[2])
    ) else $error("match value changed away from cycle start");

    unreleased_hold_a: assert property (
        !release_pending[1] |=> $stable(active_w[1])
    ) else $error("unreleased match value took effect");

    capture_gate_a: assert property (
        (cnt_mode == MCPT_MODE_RISE && !cap_rise && !count_clear)
            |=> ($stable(pc_q) && $stable(tc_q))
    ) else $error("counted without a capture edge");

    cycle_start_c: cover property (pwm_mode_en && hit_w[0] && out_en[1]);
    neg_pulse_c:   cover property (dbl_edge[2] && pwm_out[2] ##1 !pwm_out[2]);
    dbl_rise_c:    cover property (dbl_edge[2] && hit_w[1] ##1 pwm_out[2]);
    transfer_c:    cover property (release_pending[2] ##1 !release_pending[2]);
    halt_c:        cover property (stop_ev ##1 !running);

endmodule

// ### bench/mcpt_timer_bench.sv
// Self-checking bench for the multi-channel pulse width timer.
// Assumes mcpt_pkg is compiled first; drives every port of mcpt_timer directly.
`timescale 1ns/1ps

module mcpt_timer_bench
    import mcpt_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        count_en = 1'b0;
    logic        count_clear = 1'b0;
    logic        pwm_mode_en = 1'b0;
    mcpt_mode_e  cnt_mode = MCPT_MODE_TIMER;
    logic        cap_sel = 1'b0;
    logic [1:0]  cap_in = 2'h0;
    logic [31:0] prescale_limit = 32'h0;
    logic        mr_wr_en = 1'b0;
    logic [2:0]  mr_wr_sel = 3'h0;
    logic [31:0] mr_wr_data = 32'h0;
    logic [6:0]  mr_release = 7'h0;
    logic [6:0]  irq_en = 7'h0;
    logic [6:0]  stop_en = 7'h0;
    logic [6:0]  reset_en = 7'h0;
    logic [6:0]  flag_clr = 7'h0;
    logic [6:1]  out_en = 6'h0;
    logic [6:2]  dbl_edge = 5'h0;
    logic [31:0] timer_count;
    logic [31:0] prescale_count;
    logic [6:0]  match_flag;
    logic [6:0]  release_pending;
    logic        running;
    logic [6:1]  pwm_out;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          a;
    int          h;
    mcpt_mode_e  modes [4] = '{MCPT_MODE_RISE, MCPT_MODE_FALL, MCPT_MODE_BOTH, MCPT_MODE_RISE};
    int          exp_c [4] = '{5, 5, 10, 10};

    always #12.5 clk_sys = ~clk_sys;

    mcpt_timer u_mcpt_timer (
        .clk_sys(clk_sys), .rst(rst), .count_en(count_en), .count_clear(count_clear),
        .pwm_mode_en(pwm_mode_en), .cnt_mode(cnt_mode), .cap_sel(cap_sel), .cap_in(cap_in),
        .prescale_limit(prescale_limit), .mr_wr_en(mr_wr_en), .mr_wr_sel(mr_wr_sel),
        .mr_wr_data(mr_wr_data), .mr_release(mr_release), .irq_en(irq_en), .stop_en(stop_en),
        .reset_en(reset_en), .flag_clr(flag_clr), .out_en(out_en), .dbl_edge(dbl_edge),
        .timer_count(timer_count), .prescale_count(prescale_count), .match_flag(match_flag),
        .release_pending(release_pending), .running(running), .pwm_out(pwm_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Outputs are read mid-cycle, clear of the launching edge
    task automatic smp();
        @(negedge clk_sys);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_mr(input int ch, input logic [31:0] v, input bit rel);
        @(posedge clk_sys);
        mr_wr_en   <= 1'b1;
        mr_wr_sel  <= ch[2:0];
        mr_wr_data <= v;
        @(posedge clk_sys);
        mr_wr_en <= 1'b0;
        if (rel) mr_release[ch] <= 1'b1;
        @(posedge clk_sys);
        mr_release <= 7'h0;
    endtask

    // Phase-free duty measure: n spans whole periods
    task automatic hi_cnt(input int b, input int n, output int hc);
        hc = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (pwm_out[b] === 1'b1) hc++;
        end
    endtask

    task automatic zero();
        @(posedge clk_sys);
        count_clear <= 1'b1;
        @(posedge clk_sys);
        count_clear <= 1'b0;
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(2);
        rst <= 1'b0;
        smp();
        chk(timer_count, 32'h0);
        chk({25'h0, match_flag}, 32'h0);
        chk({26'h0, pwm_out}, 32'h0);
        $display("test reset done");
        @(posedge clk_sys);
        count_en <= 1'b1;
        cyc(3);
        smp();
        a = timer_count;
        repeat (10) smp();
        chk(timer_count - a, 32'ha);
        @(posedge clk_sys);
        prescale_limit <= 32'h2;
        zero();
        smp();
        a = timer_count;
        repeat (12) smp();
        chk(timer_count - a, 32'h4);
        chk({31'h0, prescale_count <= 32'h2}, 32'h1);
        $display("test count done");
        @(posedge clk_sys);
        prescale_limit <= 32'h0;
        reset_en[1] <= 1'b1;
        irq_en[1] <= 1'b1;
        wr_mr(1, 32'h3, 1'b1);
        zero();
        a = 0;
        repeat (12) begin
            smp();
            if (timer_count > a) a = timer_count;
        end
        chk(a, 32'h3);
        chk({31'h0, match_flag[1]}, 32'h1);
        @(posedge clk_sys);
        irq_en[1] <= 1'b0;
        flag_clr[1] <= 1'b1;
        @(posedge clk_sys);
        flag_clr <= 7'h0;
        cyc(3);
        smp();
        chk({31'h0, match_flag[1]}, 32'h0);
        $display("test clear done");
        wr_mr(2, 32'h2, 1'b1);
        stop_en[2] <= 1'b1;
        zero();
        cyc(8);
        smp();
        chk(timer_count, 32'h2);
        chk({31'h0, running}, 32'h0);
        @(posedge clk_sys);
        count_en <= 1'b0;
        stop_en <= 7'h0;
        reset_en <= 7'h0;
        @(posedge clk_sys);
        count_en <= 1'b1;
        cyc(2);
        smp();
        chk({31'h0, running}, 32'h1);
        $display("test stop done");
        // Values written in timer mode take effect at once
        wr_mr(0, 32'h4, 1'b1);
        wr_mr(1, 32'h2, 1'b1);
        @(posedge clk_sys);
        out_en[1] <= 1'b1;
        pwm_mode_en <= 1'b1;
        zero();
        cyc(12);
        hi_cnt(1, 10, h);
        chk(h, 32'h6);
        wr_mr(1, 32'h1, 1'b0);
        cyc(6);
        hi_cnt(1, 10, h);
        chk(h, 32'h6);
        @(posedge clk_sys);
        mr_release[1] <= 1'b1;
        @(posedge clk_sys);
        mr_release <= 7'h0;
        smp();
        chk({31'h0, release_pending[1]}, 32'h1);
        a = 0;
        while (release_pending[1] !== 1'b0) begin
            smp();
            a++;
            if (a > 20) begin
                n_fail++;
                end_sim();
            end
        end
        cyc(6);
        hi_cnt(1, 10, h);
        chk(h, 32'h4);
        $display("test single done");
        wr_mr(2, 32'h3, 1'b1);
        @(posedge clk_sys);
        dbl_edge[2] <= 1'b1;
        out_en[2] <= 1'b1;
        cyc(12);
        hi_cnt(2, 10, h);
        chk(h, 32'h4);
        wr_mr(1, 32'h3, 1'b1);
        wr_mr(2, 32'h1, 1'b1);
        cyc(12);
        hi_cnt(2, 10, h);
        chk(h, 32'h6);
        $display("test double done");
        @(posedge clk_sys);
        pwm_mode_en <= 1'b0;
        cyc(3);
        smp();
        chk({26'h0, pwm_out}, 32'h0);
        $display("test timer mode done");
        @(posedge clk_sys);
        out_en <= 6'h0;
        cap_sel <= 1'b1;
        // Input 0 toggles twice as often, so a wrong select shows
        // Last pass selects input 0 and expects its doubled edge count
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_sys);
            cnt_mode <= modes[m];
            cap_sel  <= (m < 3);
            zero();
            for (int i = 0; i < 20; i++) begin
                cyc(2);
                cap_in <= {cap_in[1] ^ (i % 2 == 0), ~cap_in[0]};
            end
            cyc(6);
            smp();
            chk(timer_count, exp_c[m]);
        end
        $display("test capture done");
        end_sim();
    end
endmodule
